//--- itc_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Byte-access field picks low, high or both
// - Access field 00 latches the current count
// - Bits 3:1 choose one of six modes
// - Mode 0 raises output at terminal count
// - Mode 1 is gate-retriggerable one-shot
// - Mode X10 divides input clock by n
// - Mode X11 makes a square wave
// - Mode 4 strobe started by count write
// - Mode 5 strobe started by gate edge
// - Bit 0 clear counts down in binary
// - Bit 0 set counts down in BCD
// - Bits 7:6 select counter 0, 1, 2
// - Top bits 11 mean read-back command
// - Read-back captures count, mode, output, null flag
// - Port reads return latched status and/or count
// - Bit 5 low latches selected counts
// - Bit 4 low latches selected status bytes
// - Bits 3, 2, 1 select counters 2, 1, 0
module itc_timer (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // I/O port access
  input  wire logic [7:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output var  logic [7:0] io_rdata_q,
  // Counter pins
  input  wire logic [itc_pkg::NUM_CNT-1:0] cnt_clk_pin,
  input  wire logic [itc_pkg::NUM_CNT-1:0] cnt_gate_pin,
  output wire logic [itc_pkg::NUM_CNT-1:0] cnt_out
);
  import itc_pkg::*;

  logic [NUM_CNT-1:0] clk_s1_q, clk_s2_q, clk_s3_q;
  logic [NUM_CNT-1:0] gate_s1_q, gate_s2_q, gate_s3_q;
  logic               wr_ctl;
  logic               rb_cmd;
  logic [1:0]         rw_field;
  logic [7:0]         rdata_d;
  logic [15:0]        ce        [NUM_CNT];
  logic [2:0]         mode      [NUM_CNT];
  logic               bcd       [NUM_CNT];
  logic               null_w    [NUM_CNT];
  logic [1:0]         rw_q      [NUM_CNT];
  logic               wr_hi_q   [NUM_CNT];
  logic [7:0]         lo_hold_q [NUM_CNT];
  logic [15:0]        cnt_lat_q [NUM_CNT];
  logic               cnt_lat_v_q [NUM_CNT];
  logic               rd_hi_q   [NUM_CNT];
  logic [7:0]         st_lat_q  [NUM_CNT];
  logic               st_lat_v_q [NUM_CNT];
  logic [7:0]         rd_byte   [NUM_CNT];
  logic               cnt_req   [NUM_CNT];
  logic               port_rd   [NUM_CNT];
  logic               prog      [NUM_CNT];

  // Pins are asynchronous to sys_clk; third stage only for edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clk_s1_q  <= '0;
      clk_s2_q  <= '0;
      clk_s3_q  <= '0;
      gate_s1_q <= '0;
      gate_s2_q <= '0;
      gate_s3_q <= '0;
    end else begin
      clk_s1_q  <= cnt_clk_pin;
      clk_s2_q  <= clk_s1_q;
      clk_s3_q  <= clk_s2_q;
      gate_s1_q <= cnt_gate_pin;
      gate_s2_q <= gate_s1_q;
      gate_s3_q <= gate_s2_q;
    end
  end

  assign wr_ctl   = io_wr && io_addr == ADDR_CTL;
  assign rb_cmd   = wr_ctl && io_wdata[CW_SEL_HI:CW_SEL_LO] == SEL_RB;
  assign rw_field = io_wdata[CW_RW_HI:CW_RW_LO];

  for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
    logic        sel_hit;
    logic        rb_sel;
    logic        st_req;
    logic        port_wr;
    logic        load;
    logic [15:0] cr_val;
    logic [15:0] src;

    assign sel_hit    = wr_ctl && io_wdata[CW_SEL_HI:CW_SEL_LO] == 2'(i);
    assign prog[i]    = sel_hit && rw_field != RW_LATCH;
    assign rb_sel     = rb_cmd && io_wdata[RB_SEL0 + i];
    assign cnt_req[i] = (sel_hit && rw_field == RW_LATCH)
                        || (rb_sel && !io_wdata[RB_NOCNT]);
    assign st_req     = rb_sel && !io_wdata[RB_NOST];
    assign port_wr    = io_wr && itc_port_hit(io_addr, i);
    assign port_rd[i] = io_rd && itc_port_hit(io_addr, i);
    assign load       = port_wr && (rw_q[i] != RW_BOTH || wr_hi_q[i]);
    assign cr_val     = rw_q[i] == RW_LSB ? {8'h00, io_wdata} :
                        rw_q[i] == RW_MSB ? {io_wdata, 8'h00} : {io_wdata, lo_hold_q[i]};
    assign src        = cnt_lat_v_q[i] ? cnt_lat_q[i] : ce[i];

    always_comb begin
      if (st_lat_v_q[i]) begin
        rd_byte[i] = st_lat_q[i];
      end else if (rw_q[i] == RW_MSB || (rw_q[i] == RW_BOTH && rd_hi_q[i])) begin
        rd_byte[i] = src[15:8];
      end else begin
        rd_byte[i] = src[7:0];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        rw_q[i]      <= RST_RW;
        wr_hi_q[i]   <= 1'b0;
        lo_hold_q[i] <= 8'h00;
      end else if (prog[i]) begin
        rw_q[i]    <= rw_field;
        wr_hi_q[i] <= 1'b0;
      end else if (port_wr && rw_q[i] == RW_BOTH) begin
        wr_hi_q[i] <= ~wr_hi_q[i];
        if (!wr_hi_q[i]) begin
          lo_hold_q[i] <= io_wdata;
        end
      end
    end

    // Status goes first; the count byte pointer waits behind it
    always_ff @(posedge sys_clk) begin
      if (!rst_n || prog[i]) begin
        st_lat_v_q[i]  <= 1'b0;
        cnt_lat_v_q[i] <= 1'b0;
        rd_hi_q[i]     <= 1'b0;
        cnt_lat_q[i]   <= RST_COUNT;
        st_lat_q[i]    <= 8'h00;
      end else begin
        if (port_rd[i] && st_lat_v_q[i]) begin
          st_lat_v_q[i] <= 1'b0;
        end else if (port_rd[i]) begin
          rd_hi_q[i] <= rw_q[i] == RW_BOTH && !rd_hi_q[i];
          if (rw_q[i] != RW_BOTH || rd_hi_q[i]) begin
            cnt_lat_v_q[i] <= 1'b0;
          end
        end
        // Setting after clearing lets a same-cycle latch win
        if (cnt_req[i] && !cnt_lat_v_q[i]) begin
          cnt_lat_q[i]   <= ce[i];
          cnt_lat_v_q[i] <= 1'b1;
        end
        if (st_req && !st_lat_v_q[i]) begin
          st_lat_q[i]   <= {cnt_out[i], null_w[i], rw_q[i], mode[i], bcd[i]};
          st_lat_v_q[i] <= 1'b1;
        end
      end
    end

    itc_counter itc_counter_inst (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .tick      (clk_s2_q[i] && !clk_s3_q[i]),
      .gate      (gate_s2_q[i]),
      .gate_rise (gate_s2_q[i] && !gate_s3_q[i]),
      .prog      (prog[i]),
      .prog_mode (io_wdata[CW_MODE_HI:CW_MODE_LO]),
      .prog_bcd  (io_wdata[CW_BCD]),
      .load      (load),
      .cr_val    (cr_val),
      .ce_q      (ce[i]),
      .mode_q    (mode[i]),
      .bcd_q     (bcd[i]),
      .out_q     (cnt_out[i]),
      .null_q    (null_w[i])
    );
  end

  // Unmapped and control-port reads return zero
  always_comb begin
    rdata_d = RST_RDATA;
    for (int k = 0; k < NUM_CNT; k++) begin
      if (itc_port_hit(io_addr, k)) begin
        rdata_d = rd_byte[k];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      io_rdata_q <= RST_RDATA;
    end else if (io_rd) begin
      io_rdata_q <= rdata_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  latch_take_a: assert property (cnt_req[0] && !cnt_lat_v_q[0] |=>
    cnt_lat_v_q[0] && cnt_lat_q[0] == $past(ce[0]))
    else $error("count latch did not capture");
  latch_hold_a: assert property (cnt_lat_v_q[0] && !port_rd[0] && !prog[0] |=>
    cnt_lat_v_q[0] && $stable(cnt_lat_q[0]))
    else $error("pending latch was disturbed");
  rb_skip_a: assert property (rb_cmd && !io_wdata[RB_SEL0] && !cnt_lat_v_q[0] && !st_lat_v_q[0]
    |=> !cnt_lat_v_q[0] && !st_lat_v_q[0])
    else $error("unselected counter was latched");
  rb_nocnt_a: assert property (rb_cmd && io_wdata[RB_NOCNT] && !cnt_lat_v_q[0] |=> !cnt_lat_v_q[0])
    else $error("count latched with bit 5 high");
  rb_status_a: assert property (rb_cmd && io_wdata[RB_SEL0] && !io_wdata[RB_NOST] && !st_lat_v_q[0]
    |=> st_lat_v_q[0] && st_lat_q[0][ST_OUT] == $past(cnt_out[0])
        && st_lat_q[0][ST_NULL] == $past(null_w[0]))
    else $error("status byte not captured");
  status_first_a: assert property (port_rd[0] && !io_wr && st_lat_v_q[0] && cnt_lat_v_q[0]
    |=> io_rdata_q == $past(st_lat_q[0]) && cnt_lat_v_q[0] && !st_lat_v_q[0])
    else $error("status not returned first");
  lsb_read_a: assert property (port_rd[1] && rw_q[1] == RW_LSB && !st_lat_v_q[1] && !cnt_lat_v_q[1]
    |=> io_rdata_q == $past(ce[1][7:0]))
    else $error("low byte read mismatch");
  both_read_a: assert property (port_rd[0] && !io_wr && rw_q[0] == RW_BOTH && !st_lat_v_q[0]
    && cnt_lat_v_q[0] && !rd_hi_q[0] |=> rd_hi_q[0] && cnt_lat_v_q[0]
    && io_rdata_q == $past(cnt_lat_q[0][7:0]))
    else $error("latched count released early");
  latch_release_a: assert property (port_rd[0] && !io_wr && rw_q[0] == RW_BOTH && !st_lat_v_q[0]
    && cnt_lat_v_q[0] && rd_hi_q[0] |=> !cnt_lat_v_q[0] && io_rdata_q == $past(cnt_lat_q[0][15:8]))
    else $error("latched count not released");
  rb_decode_a: assert property (rb_cmd |=> rw_q[0] == $past(rw_q[0]))
    else $error("read-back reprogrammed a counter");

  rb_both_c: cover property (rb_cmd && !io_wdata[RB_NOCNT] && !io_wdata[RB_NOST] && io_wdata[RB_SEL0]);
  latch_read_c: cover property (cnt_lat_v_q[0] && port_rd[0] ##1 !cnt_lat_v_q[0]);
  mode2_run_c: cover property (itc_mode_norm(mode[0]) == MODE_2 && !cnt_out[0]);
endmodule : itc_timer
`default_nettype wire

//--- itc_pkg.sv
`default_nettype none
package itc_pkg;
  localparam int NUM_CNT = 3;

  // Port map on the I/O bus
  localparam logic [7:0] ADDR_CNT0 = 8'h40;
  localparam logic [7:0] ADDR_CTL  = 8'h43;

  // Control word fields
  localparam int CW_SEL_HI  = 7;
  localparam int CW_SEL_LO  = 6;
  localparam int CW_RW_HI   = 5;
  localparam int CW_RW_LO   = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD     = 0;
  localparam int RB_NOCNT   = 5;
  localparam int RB_NOST    = 4;
  localparam int RB_SEL0    = 1;
  localparam logic [1:0] SEL_RB = 2'h3;

  // Byte access codes
  localparam logic [1:0] RW_LATCH = 2'h0;
  localparam logic [1:0] RW_LSB   = 2'h1;
  localparam logic [1:0] RW_MSB   = 2'h2;
  localparam logic [1:0] RW_BOTH  = 2'h3;

  // Normalised mode codes
  localparam logic [2:0] MODE_0 = 3'h0;
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;

  // Status byte fields
  localparam int ST_OUT  = 7;
  localparam int ST_NULL = 6;

  // Count values and reset values
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [15:0] CNT_TWO   = 16'h0002;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0]  RST_RW    = 2'h3;
  localparam logic [2:0]  RST_MODE  = 3'h0;
  localparam logic        RST_BCD   = 1'b0;
  localparam logic        RST_OUT   = 1'b0;
  localparam logic [7:0]  RST_RDATA = 8'h00;

  typedef enum logic [1:0] {CE_IDLE, CE_WAIT, CE_RUN} itc_ce_e;

  // Top mode bit is a don't-care for the two periodic modes
  function automatic logic [2:0] itc_mode_norm(input logic [2:0] m);
    return m[1] ? {1'b0, m[1:0]} : m;
  endfunction : itc_mode_norm

  function automatic logic itc_port_hit(input logic [7:0] addr, input int idx);
    return addr == (ADDR_CNT0 + 8'(idx));
  endfunction : itc_port_hit
endpackage : itc_pkg
`default_nettype wire

//--- itc_counter.sv
`timescale 1ns/1ps
`default_nettype none
module itc_counter (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Synchronised pin events
  input  wire logic        tick,
  input  wire logic        gate,
  input  wire logic        gate_rise,
  // Programming
  input  wire logic        prog,
  input  wire logic [2:0]  prog_mode,
  input  wire logic        prog_bcd,
  input  wire logic        load,
  input  wire logic [15:0] cr_val,
  // Counter state
  output var  logic [15:0] ce_q,
  output var  logic [2:0]  mode_q,
  output var  logic        bcd_q,
  output var  logic        out_q,
  output var  logic        null_q
);
  import itc_pkg::*;

  itc_ce_e     st_q;
  logic [15:0] cr_q;
  logic        trig_q;
  logic [2:0]  m;
  logic        hw_trig;
  logic        run_en;
  logic        do_load;
  logic        step;

  // Decade borrow chain when in BCD, plain wrap otherwise
  function automatic logic [15:0] itc_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic        brw;
    r   = v;
    brw = 1'b1;
    if (!bcd) begin
      r = v - CNT_ONE;
    end else begin
      for (int d = 0; d < 4; d++) begin
        if (brw && r[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = 4'h9;
        end else if (brw) begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          brw = 1'b0;
        end
      end
    end
    return r;
  endfunction : itc_dec

  assign m       = itc_mode_norm(mode_q);
  assign hw_trig = (m == MODE_1) || (m == MODE_5);
  // Gate low pauses every mode except the gate-started ones
  assign run_en  = hw_trig || gate;
  assign do_load = tick && (trig_q || (!hw_trig && st_q == CE_WAIT));
  assign step    = tick && st_q == CE_RUN && run_en;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_q <= RST_MODE;
      bcd_q  <= RST_BCD;
    end else if (prog) begin
      mode_q <= prog_mode;
      bcd_q  <= prog_bcd;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || prog) begin
      trig_q <= 1'b0;
    end else if (gate_rise && st_q != CE_IDLE && m != MODE_0 && m != MODE_4) begin
      trig_q <= 1'b1;
    end else if (do_load) begin
      trig_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q   <= CE_IDLE;
      ce_q   <= RST_COUNT;
      cr_q   <= RST_COUNT;
      out_q  <= RST_OUT;
      null_q <= 1'b1;
    end else if (prog) begin
      st_q   <= CE_IDLE;
      null_q <= 1'b1;
      out_q  <= itc_mode_norm(prog_mode) != MODE_0;
    end else if (load) begin
      cr_q   <= cr_val;
      null_q <= 1'b1;
      // Periodic modes pick up a new count only at the next reload
      if (st_q == CE_IDLE || m == MODE_0 || m == MODE_4) begin
        st_q <= CE_WAIT;
      end
      if (m == MODE_0) begin
        out_q <= 1'b0;
      end
    end else if (do_load) begin
      ce_q   <= cr_q;
      null_q <= 1'b0;
      st_q   <= CE_RUN;
      out_q  <= m != MODE_0 && m != MODE_1;
    end else if (st_q == CE_RUN && !run_en && (m == MODE_2 || m == MODE_3)) begin
      out_q <= 1'b1;
    end else if (step) begin
      case (m)
        MODE_2: begin
          if (ce_q == CNT_ONE) begin
            ce_q  <= cr_q;
            out_q <= 1'b1;
          end else begin
            ce_q  <= itc_dec(ce_q, bcd_q);
            out_q <= ce_q != CNT_TWO;
          end
        end
        MODE_3: begin
          if (ce_q == CNT_ONE || ce_q == CNT_TWO) begin
            ce_q  <= cr_q;
            out_q <= ~out_q;
          end else begin
            ce_q <= itc_dec(itc_dec(ce_q, bcd_q), bcd_q);
          end
        end
        MODE_4, MODE_5: begin
          ce_q  <= itc_dec(ce_q, bcd_q);
          out_q <= ce_q != CNT_ONE;
        end
        default: begin
          ce_q <= itc_dec(ce_q, bcd_q);
          if (ce_q == CNT_ONE) begin
            out_q <= 1'b1;
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  mode0_prog_a: assert property (prog && itc_mode_norm(prog_mode) == MODE_0 |=> !out_q)
    else $error("mode 0 output not low after programming");
  oneshot_start_a: assert property (!prog && !load && do_load && m == MODE_1 |=>
    !out_q && !null_q && ce_q == $past(cr_q))
    else $error("one-shot did not start on trigger");
  rate_reload_a: assert property (!prog && !load && !do_load && step && m == MODE_2
    && ce_q == CNT_ONE |=> out_q && ce_q == $past(cr_q))
    else $error("rate generator did not reload");
  bin_step_a: assert property (!prog && !load && !do_load && step && m == MODE_0 && !bcd_q
    |=> ce_q == $past(ce_q) - CNT_ONE)
    else $error("binary count did not step by one");
endmodule : itc_counter
`default_nettype wire

//--- itc_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module itc_timer_tb_top;
  import itc_pkg::*;

  logic               sys_clk;
  logic               rst_n;
  logic [7:0]         io_addr;
  logic               io_wr;
  logic               io_rd;
  logic [7:0]         io_wdata;
  logic [7:0]         io_rdata_q;
  logic [NUM_CNT-1:0] cnt_clk_pin;
  logic [NUM_CNT-1:0] cnt_gate_pin;
  logic [NUM_CNT-1:0] cnt_out;
  int                 mismatches;
  int                 n_checks;

  itc_timer itc_timer_inst (
    .sys_clk      (sys_clk),
    .rst_n        (rst_n),
    .io_addr      (io_addr),
    .io_wr        (io_wr),
    .io_rd        (io_rd),
    .io_wdata     (io_wdata),
    .io_rdata_q   (io_rdata_q),
    .cnt_clk_pin  (cnt_clk_pin),
    .cnt_gate_pin (cnt_gate_pin),
    .cnt_out      (cnt_out)
  );

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
    n_checks++;
    if ((got & mask) !== (exp & mask)) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_out(input int idx, input logic exp);
    chk({7'h00, cnt_out[idx]}, {7'h00, exp}, 8'h01);
  endtask : chk_out

  // Low phase long enough for the gate synchroniser to see a rising edge
  task automatic gate_pulse(input int idx);
    @(posedge sys_clk);
    #1;
    cnt_gate_pin[idx] = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    cnt_gate_pin[idx] = 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : gate_pulse

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    io_addr  = addr;
    io_wdata = data;
    io_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    io_wr    = 1'b0;
  endtask : wr

  // Data lands one cycle after the read edge and holds until the next read
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic [7:0] mask = 8'hFF);
    @(posedge sys_clk);
    #1;
    io_addr = addr;
    io_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    io_rd   = 1'b0;
    @(posedge sys_clk);
    #1;
    chk(io_rdata_q, exp, mask);
  endtask : rd

  // Pulse wide enough to pass the two-flop synchroniser
  task automatic tick(input int idx);
    @(posedge sys_clk);
    #1;
    cnt_clk_pin[idx] = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    cnt_clk_pin[idx] = 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : tick

  task automatic prog(input logic [7:0] cw, input logic [7:0] port, input logic [7:0] lo, input logic [7:0] hi);
    wr(ADDR_CTL, cw);
    wr(port, lo);
    wr(port, hi);
  endtask : prog

  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    wrap_up();
  end

  initial begin
    rst_n        = 1'b0;
    io_addr      = 8'h00;
    io_wr        = 1'b0;
    io_rd        = 1'b0;
    io_wdata     = 8'h00;
    cnt_clk_pin  = 3'h0;
    cnt_gate_pin = 3'h7;
    mismatches   = 0;
    n_checks     = 0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;

    rd(ADDR_CTL, 8'h00);
    rd(8'h44, 8'h00);
    wr(ADDR_CTL, 8'hE2);
    rd(8'h40, 8'h70);
    $display("test reset_status done");

    prog(8'h30, 8'h40, 8'h05, 8'h00);
    wr(ADDR_CTL, 8'hE2);
    rd(8'h40, 8'h70);
    tick(0);
    wr(ADDR_CTL, 8'hC2);
    rd(8'h40, 8'h30);
    rd(8'h40, 8'h05);
    rd(8'h40, 8'h00);
    repeat (4) tick(0);
    chk_out(0, 1'b0);
    tick(0);
    chk_out(0, 1'b1);
    wr(ADDR_CTL, 8'hE2);
    rd(8'h40, 8'hB0);
    $display("test mode0_terminal done");

    prog(8'h30, 8'h40, 8'h10, 8'h00);
    tick(0);
    wr(ADDR_CTL, 8'h00);
    tick(0);
    // Second latch before reading must leave the first snapshot
    wr(ADDR_CTL, 8'h00);
    rd(8'h40, 8'h10);
    rd(8'h40, 8'h00);
    wr(ADDR_CTL, 8'h00);
    rd(8'h40, 8'h0F);
    rd(8'h40, 8'h00);
    $display("test counter_latch done");

    wr(ADDR_CTL, 8'h50);
    wr(8'h41, 8'h12);
    tick(1);
    wr(ADDR_CTL, 8'h40);
    rd(8'h41, 8'h12);
    rd(8'h41, 8'h12);
    wr(ADDR_CTL, 8'hA0);
    wr(8'h42, 8'h34);
    tick(2);
    wr(ADDR_CTL, 8'h80);
    rd(8'h42, 8'h34);
    $display("test byte_access done");

    prog(8'hB1, 8'h42, 8'h10, 8'h00);
    tick(2);
    tick(2);
    wr(ADDR_CTL, 8'hD8);
    rd(8'h42, 8'h09);
    rd(8'h42, 8'h00);
    $display("test bcd_count done");

    wr(ADDR_CTL, 8'hDE);
    rd(8'h40, 8'h0F);
    rd(8'h40, 8'h00);
    rd(8'h41, 8'h12);
    rd(8'h42, 8'h09);
    rd(8'h42, 8'h00);
    $display("test readback_multi done");

    // Out and null bits depend on mode timing, so only the programmed fields are compared
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_CTL, {2'h1, 2'h3, 3'(m), 1'(m % 2)});
      wr(ADDR_CTL, 8'hE4);
      rd(8'h41, {2'h0, 2'h3, 3'(m), 1'(m % 2)}, 8'h3F);
    end
    $display("test mode_codes done");

    // Divide by three: output low from the tick that sees count two until the tick that sees count one
    prog(8'h34, 8'h40, 8'h03, 8'h00);
    repeat (2) tick(0);
    chk_out(0, 1'b1);
    tick(0);
    chk_out(0, 1'b0);
    tick(0);
    chk_out(0, 1'b1);
    wr(ADDR_CTL, 8'h00);
    rd(8'h40, 8'h03);
    rd(8'h40, 8'h00);
    $display("test rate_gen done");

    wr(ADDR_CTL, 8'h96);
    wr(8'h42, 8'h04);
    repeat (3) tick(2);
    chk_out(2, 1'b0);
    repeat (2) tick(2);
    chk_out(2, 1'b1);
    wr(ADDR_CTL, 8'h98);
    wr(8'h42, 8'h02);
    repeat (3) tick(2);
    chk_out(2, 1'b0);
    tick(2);
    chk_out(2, 1'b1);
    $display("test square_soft_strobe done");

    // Without a gate edge the one-shot must not start
    wr(ADDR_CTL, 8'h52);
    wr(8'h41, 8'h02);
    tick(1);
    chk_out(1, 1'b1);
    gate_pulse(1);
    tick(1);
    chk_out(1, 1'b0);
    repeat (2) tick(1);
    chk_out(1, 1'b1);
    wr(ADDR_CTL, 8'h5A);
    wr(8'h41, 8'h02);
    gate_pulse(1);
    repeat (3) tick(1);
    chk_out(1, 1'b0);
    tick(1);
    chk_out(1, 1'b1);
    $display("test gate_modes done");

    wrap_up();
  end
endmodule : itc_timer_tb_top
`default_nettype wire
